// >>> plf_fabric.sv
// Programmable logic fabric: 32 lookup elements, feedback routing, block clocking,
// pin in/out, readback and four level interrupts, configured over Avalon-MM.
// Assumes pin_in is asynchronous and ext_tick comes from logic on clk_sys.
//
// Operation
// [R1] Four blocks of eight, thirty-two elements
// [R2] Each element: two-input lookup plus flip-flop
// [R3] Outputs reach interrupts, readback and pins
// [R4] Input pins always feed their elements
// [R5] Per-element bypass, per-block shared clock select
// [R6] Even and odd feedback muxes per element
// [R7] Block element 0 takes previous block's 7
// [R8] Upper elements take element n-16 output
// [R9] Lower elements take software input bits
// [R10] Four interrupts select any element output
// [R11] Interrupts active high, level while selected high
// [R12] Software builds inverters for active-low interrupts
// [R13] Software builds edge detectors for edge interrupts
// [R14] Software assigns pins to fabric first
// [R15] Four-bit field selects the lookup function
// [R16] Even select codes pick 0/ring,2,4,6
// [R17] Odd select codes pick 1,3,5,7
// [R18] Write lock set once, blocks configuration
// [R19] Bypass gives lookup result, else registered
// [R20] Configuration and flip-flops reset to zero
`timescale 1ns/1ns
`default_nettype none

module plf_fabric (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [13:0] pin_in,
	input  wire logic [3:0]  ext_tick,
	output logic      [12:0] pin_out,
	output logic      [3:0]  irq
);

	// Merge the low two byte lanes of a write into a 16-bit register
	function automatic logic [15:0] be_merge(input logic [15:0] old_v,
		input logic [31:0] wdata, input logic [3:0] be);
		be_merge = old_v;
		if (be[0])
			be_merge[7:0] = wdata[7:0];
		if (be[1])
			be_merge[15:8] = wdata[15:8];
	endfunction

	// Element index fed to the even feedback mux
	function automatic logic [4:0] even_src(input logic [4:0] n, input logic [1:0] sel);
		if (sel == 2'b00 && n[2:0] == 3'b000)
			even_src = n - 5'd1;
		else
			even_src = {n[4:3], sel, 1'b0};
	endfunction

	// Element index fed to the odd feedback mux
	function automatic logic [4:0] odd_src(input logic [4:0] n, input logic [1:0] sel);
		odd_src = {n[4:3], sel, 1'b1};
	endfunction

	// Truth-table lookup: bit {A,B} of the function field
	function automatic logic lut(input logic [3:0] func, input logic a, input logic b);
		lut = func[{a, b}];
	endfunction

	// Avalon slave: one wait cycle, answer on the second
	logic        ack_q;
	logic [31:0] rdata_q;
	logic        req;
	logic        wr_fire;
	logic        wr_cfg;

	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_fire         = avs_write & ack_q;

	// Configuration state
	plf_pkg::plf_elem_cfg_t cfg_q [plf_pkg::NUM_ELEM];
	logic [11:0]            clk_sel_q;
	plf_pkg::plf_irq_sel_t  irq_sel_q [plf_pkg::NUM_IRQ];
	logic [15:0]            din_q;
	logic                   lock_q;

	// [R18] configuration writes blocked once locked
	assign wr_cfg = wr_fire & ~lock_q;

	// Address decode
	logic       hit_elem;
	logic       hit_clk;
	logic       hit_irq_lo;
	logic       hit_irq_hi;
	logic       hit_din;
	logic       hit_dout0;
	logic       hit_dout1;
	logic       hit_lock;
	logic [4:0] elem_idx;

	assign hit_elem   = avs_address[7] == plf_pkg::OFF_ELEM_BASE[7];
	assign elem_idx   = avs_address[6:2];
	assign hit_clk    = avs_address[7:2] == plf_pkg::OFF_CLK_SEL[7:2];
	assign hit_irq_lo = avs_address[7:2] == plf_pkg::OFF_IRQ_LO[7:2];
	assign hit_irq_hi = avs_address[7:2] == plf_pkg::OFF_IRQ_HI[7:2];
	assign hit_din    = avs_address[7:2] == plf_pkg::OFF_DIN[7:2];
	assign hit_dout0  = avs_address[7:2] == plf_pkg::OFF_DOUT0[7:2];
	assign hit_dout1  = avs_address[7:2] == plf_pkg::OFF_DOUT1[7:2];
	assign hit_lock   = avs_address[7:2] == plf_pkg::OFF_LOCK[7:2];

	// Fabric signals
	logic [31:0] elem_q;
	logic [31:0] elem_out;
	logic [31:0] lut_res;
	logic [31:0] a_in;
	logic [31:0] b_in;
	logic [31:0] even_v;
	logic [31:0] odd_v;
	logic [31:0] extra_in;
	logic [31:0] soft_in;
	logic [3:0]  blk_tick;

	// Pin synchroniser
	logic [13:0] pin_s1_q;
	logic [13:0] pin_s2_q;
	logic [15:0] pin_by_elem;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_s1_q <= 14'h0000;
			pin_s2_q <= 14'h0000;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// [R4] pins feed elements regardless of port function
	always_comb begin
		pin_by_elem = 16'h0000;
		for (int i = 0; i < plf_pkg::NUM_PIN_IN; i++) begin
			pin_by_elem[plf_pkg::PIN_IN_ELEM[i][3:0]] = pin_s2_q[i];
		end
	end

	// Clock enables for the block flip-flops
	logic [1:0] div_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			div_q <= 2'b00;
		else
			div_q <= div_q + 2'b01;
	end

	// [R5] one shared clock source per block
	generate
		for (genvar k = 0; k < plf_pkg::NUM_BLK; k++) begin : g_tick
			logic [2:0] code;
			assign code = clk_sel_q[k*plf_pkg::CLK_SEL_W +: plf_pkg::CLK_SEL_W];
			assign blk_tick[k] = (code == plf_pkg::CLK_SYS)  ? 1'b1 :
			                     (code == plf_pkg::CLK_DIV2) ? div_q[0] :
			                     (code == plf_pkg::CLK_DIV4) ? &div_q :
			                     (code == plf_pkg::CLK_OFF)  ? 1'b0 :
			                     ext_tick[2'(code - plf_pkg::CLK_EXT0)];
		end
	endgenerate

	// Bypassed elements chained in a feedback ring form a combinational loop;
	// software must keep at least one registered element in any such ring.
	// [R1] thirty-two elements in four blocks
	generate
		for (genvar n = 0; n < plf_pkg::NUM_ELEM; n++) begin : g_elem
			// [R6] even and odd feedback muxes
			// [R7] [R16] [R17] select codes and ring
			assign even_v[n] = elem_out[even_src(5'(n), cfg_q[n].even_sel)];
			assign odd_v[n]  = elem_out[odd_src(5'(n), cfg_q[n].odd_sel)];
			if (n < plf_pkg::UPPER_OFFSET) begin : g_low
				// [R9] software input bits for lower blocks
				assign extra_in[n] = pin_by_elem[n];
				assign soft_in[n]  = din_q[n];
			end else begin : g_up
				// [R8] upper blocks see element n-16
				assign extra_in[n] = elem_out[n - plf_pkg::UPPER_OFFSET];
				assign soft_in[n]  = elem_out[n - plf_pkg::UPPER_OFFSET];
			end
			assign a_in[n] = cfg_q[n].a_extra ? extra_in[n] : even_v[n];
			assign b_in[n] = cfg_q[n].b_soft ? soft_in[n] : odd_v[n];
			// [R2] [R15] lookup of the two inputs
			assign lut_res[n] = lut(cfg_q[n].func, a_in[n], b_in[n]);
			// [R19] bypass or registered output
			assign elem_out[n] = cfg_q[n].bypass ? lut_res[n] : elem_q[n];

			// [R5] [R20] flip-flop on block clock, reset zero
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					elem_q[n] <= 1'b0;
				else if (blk_tick[n / plf_pkg::ELEM_PER_BLK])
					elem_q[n] <= lut_res[n];
			end
		end
	endgenerate

	logic [15:0] cfg_w;
	assign cfg_w = be_merge(16'(cfg_q[elem_idx]), avs_writedata, avs_byteenable);
	// Register writes
	// [R20] configuration resets to zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < plf_pkg::NUM_ELEM; i++) begin
				cfg_q[i] <= plf_pkg::CFG_RST;
			end
		end else if (wr_cfg && hit_elem) begin
			cfg_q[elem_idx] <= plf_pkg::plf_elem_cfg_t'(cfg_w[10:0]);
		end
	end

	logic [15:0] irq_lo_v;
	logic [15:0] irq_hi_v;
	logic [15:0] irq_lo_w;
	logic [15:0] irq_hi_w;
	logic [15:0] clk_sel_w;

	assign irq_lo_v = {2'b00, irq_sel_q[1], 2'b00, irq_sel_q[0]};
	assign irq_hi_v = {2'b00, irq_sel_q[3], 2'b00, irq_sel_q[2]};
	assign irq_lo_w = be_merge(irq_lo_v, avs_writedata, avs_byteenable);
	assign irq_hi_w = be_merge(irq_hi_v, avs_writedata, avs_byteenable);
	assign clk_sel_w = be_merge({4'h0, clk_sel_q}, avs_writedata, avs_byteenable);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			clk_sel_q <= plf_pkg::CLK_SEL_RST;
			din_q     <= plf_pkg::DIN_RST;
			for (int i = 0; i < plf_pkg::NUM_IRQ; i++) begin
				irq_sel_q[i] <= plf_pkg::IRQ_RST;
			end
		end else begin
			if (wr_cfg && hit_clk)
				clk_sel_q <= clk_sel_w[11:0];
			if (wr_fire && hit_din)
				din_q <= be_merge(din_q, avs_writedata, avs_byteenable);
			if (wr_cfg && hit_irq_lo) begin
				irq_sel_q[0] <= irq_lo_w[5:0];
				irq_sel_q[1] <= irq_lo_w[plf_pkg::IRQ_B_POS +: 6];
			end
			if (wr_cfg && hit_irq_hi) begin
				irq_sel_q[2] <= irq_hi_w[5:0];
				irq_sel_q[3] <= irq_hi_w[plf_pkg::IRQ_B_POS +: 6];
			end
		end
	end

	// [R18] lock sets on writing one, clears only by reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			lock_q <= 1'b0;
		else if (wr_fire && hit_lock && avs_byteenable[0] && avs_writedata[plf_pkg::LOCK_POS])
			lock_q <= 1'b1;
	end

	// Read mux; unmapped offsets read zero
	logic [31:0] rd_value;

	assign rd_value = hit_elem   ? {21'h0, cfg_q[elem_idx]} :
	                  hit_clk    ? {20'h0, clk_sel_q} :
	                  hit_irq_lo ? {16'h0, irq_lo_v} :
	                  hit_irq_hi ? {16'h0, irq_hi_v} :
	                  hit_din    ? {16'h0, din_q} :
	                  hit_dout0  ? {16'h0, elem_out[15:0]} :
	                  hit_dout1  ? {16'h0, elem_out[31:16]} :
	                  hit_lock   ? {31'h0, lock_q} : 32'h0000_0000;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (avs_read && !ack_q)
				rdata_q <= rd_value;
		end
	end

	assign avs_readdata = rdata_q;

	// [R3] [R10] [R11] pins and level interrupts
	logic [12:0] pin_out_q;
	logic [3:0]  irq_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_out_q <= 13'h0000;
			irq_q     <= 4'h0;
		end else begin
			for (int i = 0; i < plf_pkg::NUM_PIN_OUT; i++) begin
				pin_out_q[i] <= elem_out[plf_pkg::PIN_OUT_ELEM[i]];
			end
			for (int i = 0; i < plf_pkg::NUM_IRQ; i++) begin
				irq_q[i] <= irq_sel_q[i].enable & elem_out[irq_sel_q[i].elem];
			end
		end
	end

	assign pin_out = pin_out_q;
	assign irq     = irq_q;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_req_wait;
		req && !ack_q && avs_waitrequest;
	endsequence

	sequence s_req_done;
		!avs_waitrequest && ack_q;
	endsequence

	a_bus_one_wait: assert property (s_req_wait |=> s_req_done) // Avalon slave: one wait cycle, answer on the second
		else $error("bus answer not one cycle after request");
	a_irq_level_follow: assert property ( // [R11]
		1'b1 |=> irq[0] == $past(irq_sel_q[0].enable & elem_out[irq_sel_q[0].elem]))
		else $error("interrupt 0 does not follow selected element");
	a_irq_disabled_low: assert property ( // [R10]
		!irq_sel_q[0].enable |=> !irq[0])
		else $error("disabled interrupt asserted");
	a_ff_hold_block: assert property (!blk_tick[1] |=> $stable(elem_q[15:8])) // [R5]
		else $error("block 1 flip-flops moved without a tick");
	a_ff_capture_lut: assert property ( // [R19]
		(blk_tick[0] && !cfg_q[2].bypass) ##1 !cfg_q[2].bypass
		|-> elem_out[2] == $past(lut_res[2]))
		else $error("element 2 did not register its lookup result");
	a_bypass_comb: assert property (cfg_q[5].bypass |-> elem_out[5] == lut_res[5]) // [R19]
		else $error("bypassed element output differs from lookup");
	a_lut_xor_or: assert property ( // [R15]
		(cfg_q[2].func == plf_pkg::FN_XOR |-> lut_res[2] == (a_in[2] ^ b_in[2])) and
		(cfg_q[2].func == plf_pkg::FN_OR |-> lut_res[2] == (a_in[2] | b_in[2])))
		else $error("lookup function wrong");
	a_ring_links: assert property ( // [R7]
		(cfg_q[0].even_sel == 2'b00 |-> even_v[0] == elem_out[31]) and
		(cfg_q[8].even_sel == 2'b00 |-> even_v[8] == elem_out[7]))
		else $error("ring feedback not from previous block element 7");
	a_even_odd_sel: assert property ( // [R16] [R17]
		(cfg_q[3].even_sel == 2'b11 |-> even_v[3] == elem_out[6]) and
		(cfg_q[4].odd_sel == 2'b01 |-> odd_v[4] == elem_out[3]))
		else $error("feedback select code picks wrong element");
	a_upper_extra: assert property (cfg_q[18].a_extra |-> a_in[18] == elem_out[2]) // [R8]
		else $error("upper element extra input not element n-16");
	a_soft_input: assert property (cfg_q[2].b_soft |-> b_in[2] == din_q[2]) // [R9]
		else $error("lower element software input wrong");
	a_pin_to_elem: assert property ( // [R4]
		cfg_q[2].a_extra |-> a_in[2] == $past(pin_in[2], 2))
		else $error("pin input does not reach its element");
	a_lock_blocks_cfg: assert property ( // [R18]
		lock_q |=> lock_q && $stable(cfg_q[2]) && $stable(clk_sel_q))
		else $error("configuration changed while locked");
	a_pin_out_path: assert property (1'b1 |=> pin_out[0] == $past(elem_out[2])) // [R3]
		else $error("output pin 0 does not follow element 2");

endmodule

`default_nettype wire

// >>> plf_fabric_tb.sv
// Self-checking bench for the logic fabric: lookup, routing, clocking, interrupts, lock.
// Assumes the one-wait-state Avalon-MM slave and the port pin model.
`timescale 1ns/1ns
`default_nettype none

module plf_fabric_tb;
	logic        clk_sys;
	logic        rstn;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [13:0] pin_level;
	logic [12:0] port_cfg;
	logic [13:0] pin_in;
	logic [3:0]  ext_tick;
	logic [12:0] pin_out;
	logic [12:0] pin_seen;
	logic [3:0]  irq;
	logic [31:0] rd;
	logic [3:0]  fns [6];
	int          miscompares;
	int          compares;
	int          hits;

	plf_fabric plf_fabric_inst (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .ext_tick(ext_tick),
		.pin_out(pin_out), .irq(irq));

	plf_pin_model plf_pin_model_inst (.clk_sys(clk_sys), .rstn(rstn), .pin_level(pin_level),
		.port_cfg(port_cfg), .pin_out(pin_out), .pin_in(pin_in), .ext_tick(ext_tick),
		.pin_seen(pin_seen));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Values read just after an edge are those the slave saw at it; the watchdog ends a hang
	task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr_n;
		avs_read      <= !wr_n;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic settle;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic pins(input logic [13:0] v);
		@(posedge clk_sys);
		pin_level <= v;
		settle();
	endtask

	task automatic do_reset;
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
	endtask

	function automatic logic [31:0] ew(input logic [1:0] ev, input logic [1:0] od,
		input logic ax, input logic bs, input logic [3:0] fn, input logic by);
		return {21'h0, plf_pkg::plf_elem_cfg_t'{ev, od, ax, bs, fn, by}};
	endfunction

	initial begin
		#400000;
		miscompares++;
		final_report();
	end

	initial begin
		rstn = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		pin_level = 14'h0;
		port_cfg = 13'h1fff;
		fns = '{plf_pkg::FN_ZERO, plf_pkg::FN_XOR, plf_pkg::FN_OR, plf_pkg::FN_ONE, 4'h8, 4'h3};
		do_reset();
		rdc(8'h00, 32'h0);
		rdc(plf_pkg::OFF_CLK_SEL, 32'h0);
		rdc(plf_pkg::OFF_IRQ_LO, 32'h0);
		wr(8'h8c, 32'hffff);
		rdc(8'h8c, 32'h0);
		// Function zero keeps element 5 out of the later readback and pin checks
		wr(8'h14, 32'hffe1);
		rdc(8'h14, 32'h7e1);
		$display("test registers done");
		foreach (fns[i]) for (int ab = 0; ab < 4; ab++) begin
			wr(8'h08, ew(2'h0, 2'h0, 1'b1, 1'b1, fns[i], 1'b1));
			wr(plf_pkg::OFF_DIN, {29'h0, ab[0], 2'h0});
			pins({11'h0, ab[1], 2'h0});
			rdc(plf_pkg::OFF_DOUT0, {29'h0, fns[i][ab], 2'h0});
			chk({19'h0, pin_seen}, {31'h0, fns[i][ab]});
		end
		$display("test lookup done");
		for (int n = 0; n < 8; n++) wr(8'(4 * n), ew(2'h0, 2'h0, 1'b1, 1'b0, 4'hc, 1'b1));
		for (int c = 0; c < 4; c++) begin
			wr(8'h0c, ew(2'(c), 2'h0, 1'b0, 1'b0, 4'hc, 1'b1));
			wr(8'h10, ew(2'h0, 2'(c), 1'b0, 1'b0, 4'ha, 1'b1));
			pins(14'(3 << (2 * c)));
			bus(1'b0, plf_pkg::OFF_DOUT0, 32'h0);
			chk({30'h0, rd[4:3]}, 32'h3);
			pins(~14'(3 << (2 * c)));
			bus(1'b0, plf_pkg::OFF_DOUT0, 32'h0);
			chk({30'h0, rd[4:3]}, 32'h0);
		end
		wr(8'h20, ew(2'h0, 2'h0, 1'b0, 1'b0, 4'hc, 1'b1));
		wr(8'h48, ew(2'h0, 2'h0, 1'b1, 1'b0, 4'hc, 1'b1));
		for (int v = 0; v < 2; v++) begin
			pins(v ? 14'h0084 : 14'h3f7b);
			bus(1'b0, plf_pkg::OFF_DOUT0, 32'h0);
			chk({31'h0, rd[8]}, 32'(v));
			bus(1'b0, plf_pkg::OFF_DOUT1, 32'h0);
			chk({31'h0, rd[2]}, 32'(v));
			chk({31'h0, pin_seen[8]}, 32'(v));
		end
		$display("test routing done");
		wr(8'h08, ew(2'h0, 2'h0, 1'b1, 1'b0, 4'hc, 1'b0));
		pins(14'h0);
		wr(plf_pkg::OFF_CLK_SEL, {29'h0, plf_pkg::CLK_OFF});
		pins(14'h4);
		rdc(plf_pkg::OFF_DOUT0, 32'h0);
		wr(plf_pkg::OFF_CLK_SEL, {29'h0, plf_pkg::CLK_SYS});
		settle();
		rdc(plf_pkg::OFF_DOUT0, 32'h4);
		wr(plf_pkg::OFF_CLK_SEL, {29'h0, plf_pkg::CLK_EXT0});
		pins(14'h0);
		settle();
		rdc(plf_pkg::OFF_DOUT0, 32'h0);
		$display("test clocking done");
		wr(8'h08, ew(2'h0, 2'h0, 1'b1, 1'b0, 4'hc, 1'b1));
		wr(8'h0c, ew(2'h1, 2'h0, 1'b0, 1'b0, 4'h3, 1'b1));
		wr(plf_pkg::OFF_IRQ_LO, 32'h2322);
		wr(plf_pkg::OFF_IRQ_HI, 32'h0022);
		for (int v = 0; v < 2; v++) begin
			pins(v ? 14'h4 : 14'h0);
			chk({28'h0, irq}, v ? 32'h5 : 32'h2);
		end
		wr(plf_pkg::OFF_IRQ_LO, 32'h0);
		wr(plf_pkg::OFF_IRQ_HI, 32'h0);
		settle();
		chk({28'h0, irq}, 32'h0);
		// Edge detector: element 6 is element 2 and not its registered copy
		wr(plf_pkg::OFF_CLK_SEL, {29'h0, plf_pkg::CLK_SYS});
		wr(8'h14, ew(2'h1, 2'h0, 1'b0, 1'b0, 4'hc, 1'b0));
		wr(8'h18, ew(2'h1, 2'h2, 1'b0, 1'b0, 4'h4, 1'b1));
		pins(14'h0);
		wr(plf_pkg::OFF_IRQ_LO, 32'h0026);
		@(posedge clk_sys);
		pin_level <= 14'h4;
		hits = 0;
		repeat (8) begin
			@(posedge clk_sys);
			hits += irq[0];
		end
		chk(hits, 32'h1);
		wr(plf_pkg::OFF_IRQ_LO, 32'h0);
		$display("test interrupts done");
		wr(plf_pkg::OFF_LOCK, 32'h1);
		wr(plf_pkg::OFF_LOCK, 32'h0);
		wr(8'h08, 32'h0);
		wr(plf_pkg::OFF_DIN, 32'h5a5a);
		rdc(plf_pkg::OFF_LOCK, 32'h1);
		rdc(8'h08, ew(2'h0, 2'h0, 1'b1, 1'b0, 4'hc, 1'b1));
		rdc(plf_pkg::OFF_DIN, 32'h5a5a);
		do_reset();
		rdc(plf_pkg::OFF_LOCK, 32'h0);
		rdc(8'h08, 32'h0);
		rdc(plf_pkg::OFF_DIN, 32'h0);
		chk({15'h0, pin_seen, irq}, 32'h0);
		wr(8'h08, 32'h3);
		rdc(8'h08, 32'h3);
		$display("test lock done");
		final_report();
	end
endmodule

`default_nettype wire

// >>> plf_pin_model.sv
// Port pin model on the far side of the fabric: input pin levels and tick sources.
// Assumes the bench sets pin levels and the port function enables on clk_sys.
`timescale 1ns/1ns
`default_nettype none

module plf_pin_model (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [13:0] pin_level,
	input  wire logic [12:0] port_cfg,
	input  wire logic [12:0] pin_out,
	output logic      [13:0] pin_in,
	output logic      [3:0]  ext_tick,
	output logic      [12:0] pin_seen
);
	logic [1:0] tick_q;

	assign pin_in = pin_level;
	// Pins given to fabric
	// Unassigned pins are pulled low, so a missing enable shows as a stuck zero
	assign pin_seen = pin_out & port_cfg;
	assign ext_tick = {4{tick_q == 2'h3}};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tick_q <= 2'h0;
		end else begin
			tick_q <= tick_q + 2'h1;
		end
	end
endmodule

`default_nettype wire

// >>> plf_pkg.sv
// Constants, register map and carrier types of the programmable logic fabric.
// Assumes a 32-bit register bus with byte addresses inside the fabric window.
`default_nettype none

package plf_pkg;

	// Fabric geometry
	localparam int NUM_ELEM     = 32;
	localparam int NUM_BLK      = 4;
	localparam int ELEM_PER_BLK = 8;
	localparam int NUM_PIN_IN   = 14;
	localparam int NUM_PIN_OUT  = 13;
	localparam int NUM_IRQ      = 4;
	localparam int UPPER_OFFSET = 16;

	// Register byte offsets
	localparam logic [7:0] OFF_ELEM_BASE = 8'h00;
	localparam logic [7:0] OFF_CLK_SEL   = 8'h80;
	localparam logic [7:0] OFF_IRQ_LO    = 8'h84;
	localparam logic [7:0] OFF_IRQ_HI    = 8'h88;
	localparam logic [7:0] OFF_DIN       = 8'h90;
	localparam logic [7:0] OFF_DOUT0     = 8'h98;
	localparam logic [7:0] OFF_DOUT1     = 8'h9c;
	localparam logic [7:0] OFF_LOCK      = 8'ha0;

	// Field positions
	localparam int CLK_SEL_W  = 3;
	localparam int IRQ_B_POS  = 8;
	localparam int LOCK_POS   = 0;

	// Element configuration word, bits [10:0]; bits above read zero
	typedef struct packed {
		logic [1:0] even_sel;
		logic [1:0] odd_sel;
		logic       a_extra;
		logic       b_soft;
		logic [3:0] func;
		logic       bypass;
	} plf_elem_cfg_t;

	// One interrupt selection field
	typedef struct packed {
		logic       enable;
		logic [4:0] elem;
	} plf_irq_sel_t;

	// Reset values
	localparam plf_elem_cfg_t CFG_RST     = '0;
	localparam logic [11:0]   CLK_SEL_RST = 12'h000;
	localparam plf_irq_sel_t  IRQ_RST     = '0;
	localparam logic [15:0]   DIN_RST     = 16'h0000;

	// Block clock sources
	localparam logic [2:0] CLK_SYS  = 3'h0;
	localparam logic [2:0] CLK_EXT0 = 3'h1;
	localparam logic [2:0] CLK_DIV2 = 3'h5;
	localparam logic [2:0] CLK_DIV4 = 3'h6;
	localparam logic [2:0] CLK_OFF  = 3'h7;

	// Lookup function codes named in checks
	localparam logic [3:0] FN_ZERO = 4'h0;
	localparam logic [3:0] FN_XOR  = 4'h6;
	localparam logic [3:0] FN_OR   = 4'he;
	localparam logic [3:0] FN_ONE  = 4'hf;

	// Pin to element maps
	localparam logic [4:0] PIN_IN_ELEM [NUM_PIN_IN] = '{
		5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
		5'h07, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h0e};
	localparam logic [4:0] PIN_OUT_ELEM [NUM_PIN_OUT] = '{
		5'h02, 5'h03, 5'h04, 5'h05, 5'h0a, 5'h0b, 5'h0c,
		5'h0d, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1a};

endpackage

`default_nettype wire
